// >>> src/spi_seq_pkg.sv
// shared constants and state encoding for the spi transfer sequencer
package spi_seq_pkg;
  // clock rates
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int LINK_CLK_HZ = 66_666_667;
  localparam int SCLK_HZ = 1_000_000;
  // half serial clock period in link cycles, rounded up so sclk never exceeds SCLK_HZ
  localparam int SCLK_HALF_CYC = (LINK_CLK_HZ + 2 * SCLK_HZ - 1) / (2 * SCLK_HZ);
  localparam int DIV_W = 6;
  // chip select guard times
  localparam int CS_SETUP_NS = 200;
  localparam int CS_HOLD_NS = 200;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CS_HOLD_CYC = (CS_HOLD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int GUARD_W = 4;
  // data path
  localparam int BYTE_W = 8;
  localparam logic [7:0] FILLER_BYTE = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 16;
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_SEND = 3'h3,
    ST_RECV = 3'h2,
    ST_HOLD = 3'h6
  } seq_state_e;
endpackage : spi_seq_pkg

// >>> src/byte_fifo.sv
// parameterised valid/ready fifo with registered input ready
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire do_wr = i_in_valid & o_in_ready;
  wire do_rd = o_out_valid & i_out_ready;

  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      o_in_ready <= (next_count < (AW + 1)'(DEPTH));
    end
  end
endmodule : byte_fifo
`default_nettype wire

// >>> src/spi_xfer_seq.sv
// spi master transfer sequencer: transmit half then receive half under one chip select
//
// Summary of operation
// R1 - A combined transaction is a transmit half then a receive half with chip select held across both.
// R2 - Bytes shifted in during the transmit half are counted and dropped.
// R3 - After the last transmit-half byte completes, the receive half starts with chip select still low.
// R4 - In the receive half zero filler bytes are sent only to clock the slave's data out.
// R5 - Each byte received in the receive half is passed on in order until the receive count is met.
// R6 - The last byte of the receive half ends the transaction and releases chip select.
// R7 - A request carries a device select, a transmit count with its data and a receive count.
// R8 - A transmit-only request, once accepted, runs to the end without the requester.
// R9 - A per-device busy flag stays high while a transfer to that device runs.
// R10 - The serial engine always finishes a byte already in its shift register.
// R11 - A byte waiting in the transmit buffer moves to the shift register when it empties.
// R12 - Only one received byte is held, and an undrained byte overwritten by the next is an overrun.
// R13 - In lockstep mode the next byte is loaded only after every earlier byte was received and drained.
// R14 - Serial clock runs at 1MHz and chip select setup and hold are kept to guard times.
// R15 - Chip select is released on the last received byte, never on the last load.
// R16 - The transmit buffer is refilled as soon as it empties so bytes go back to back.
// R17 - Only the selected device is asserted, and before the first serial clock.
`timescale 1ns/1ps
`default_nettype none
module spi_xfer_seq
  import spi_seq_pkg::*;
#(
  parameter int NUM_DEV = 2,
  parameter int DEV_W = 1,
  parameter int CNT_W = 8,
  parameter int TX_FIFO_DEPTH = FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_req,
  input wire logic [DEV_W-1:0] i_dev,
  input wire logic [CNT_W-1:0] i_send_count,
  input wire logic [CNT_W-1:0] i_recv_count,
  input wire logic [BYTE_W-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [BYTE_W-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic i_rx_lockstep,
  output logic o_rx_overrun,
  output logic [NUM_DEV-1:0] o_busy,
  output logic o_done,
  output logic [NUM_DEV-1:0] o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_miso
);

  function automatic logic [NUM_DEV-1:0] dev_onehot(input logic [DEV_W-1:0] dev);
    dev_onehot = '0;
    for (int k = 0; k < NUM_DEV; k++) begin
      if (int'(dev) == k) begin
        dev_onehot[k] = 1'b1;
      end
    end
  endfunction : dev_onehot

  // ---------------- system domain ----------------
  seq_state_e state;
  seq_state_e next_state;
  logic [CNT_W-1:0] load_left;
  logic [CNT_W-1:0] got_left;
  logic [CNT_W-1:0] recv_req;
  logic [GUARD_W-1:0] guard;
  logic [BYTE_W-1:0] tx_word;
  logic req_tog;
  logic pending;
  logic ack_s1;
  logic ack_s2;
  logic ack_seen;
  logic rx_s1;
  logic rx_s2;
  logic rx_seen;
  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;

  // ---------------- link domain ----------------
  logic req_s1;
  logic req_s2;
  logic req_seen;
  logic miso_s1;
  logic miso_s2;
  logic [BYTE_W-1:0] tbuf;
  logic tbuf_full;
  logic [BYTE_W-1:0] shreg;
  logic [BYTE_W-1:0] rxsh;
  logic [2:0] bitcnt;
  logic [DIV_W-1:0] divcnt;
  logic active;
  logic [BYTE_W-1:0] rx_word;
  logic rx_tog;
  logic ack_tog;

  // system domain decode
  wire ack_evt = ack_s2 ^ ack_seen;
  wire rx_evt = rx_s2 ^ rx_seen;
  wire in_send = (state == ST_SEND);
  wire in_recv = (state == ST_RECV);
  wire dev_ok = (int'(i_dev) < NUM_DEV);
  wire accept = (state == ST_IDLE) & i_req & dev_ok & (i_send_count != '0);
  wire last_rx = rx_evt & (got_left == CNT_W'(1));
  wire guard_done = (guard == '0);
  wire src_ok = in_send ? fifo_valid : 1'b1;
  // R13 lockstep load gate
  wire lock_ok = ~i_rx_lockstep | ((load_left == got_left) & ~o_rx_valid);
  // R11 R16 refill on empty
  wire can_load = (in_send | in_recv) & ~pending & (load_left != '0) & src_ok & lock_ok;
  wire fifo_pop = can_load & in_send;
  // R4 zero filler in receive half
  wire [BYTE_W-1:0] load_byte = in_send ? fifo_data : FILLER_BYTE;
  wire rx_keep = rx_evt & in_recv;

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_data(i_tx_data),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .o_out_data(fifo_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop)
  );

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (guard_done) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        // R3 switch halves, select held
        if (last_rx) begin
          next_state = (recv_req != '0) ? ST_RECV : ST_HOLD;
        end
      end
      ST_RECV: begin
        // R6 second completion ends it
        if (last_rx) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (guard_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // R14 chip select guard times
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      guard <= '0;
    end else if (accept) begin
      guard <= GUARD_W'(CS_SETUP_CYC);
    end else if (next_state == ST_HOLD && state != ST_HOLD) begin
      guard <= GUARD_W'(CS_HOLD_CYC);
    end else if (!guard_done) begin
      guard <= guard - 1'b1;
    end
  end

  // R7 request capture and byte counters
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_left <= '0;
      got_left <= '0;
      recv_req <= '0;
    end else if (accept) begin
      load_left <= i_send_count;
      got_left <= i_send_count;
      recv_req <= i_recv_count;
    end else if (in_send && last_rx && recv_req != '0) begin
      // R1 receive half reuses the same select
      load_left <= recv_req;
      got_left <= recv_req;
    end else begin
      if (can_load) begin
        load_left <= load_left - 1'b1;
      end
      // R2 count every byte shifted in
      if (rx_evt && got_left != '0) begin
        got_left <= got_left - 1'b1;
      end
    end
  end

  // R17 single select asserted before serial clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cs_n <= '1;
      o_busy <= '0;
      o_done <= 1'b0;
    end else if (accept) begin
      o_cs_n <= ~dev_onehot(i_dev);
      // R9 busy per device
      o_busy <= dev_onehot(i_dev);
      o_done <= 1'b0;
    end else if (state == ST_HOLD && guard_done) begin
      // R15 release after last receive
      o_cs_n <= '1;
      o_busy <= '0;
      o_done <= 1'b1;
    end else begin
      o_done <= 1'b0;
    end
  end

  // R5 receive half bytes passed on in order
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_data <= BYTE_RST;
      o_rx_valid <= 1'b0;
      o_rx_overrun <= 1'b0;
    end else begin
      if (rx_keep) begin
        o_rx_data <= rx_word;
      end
      o_rx_valid <= rx_keep | (o_rx_valid & ~i_rx_ready);
      // R12 single holding byte overrun
      if (rx_keep && o_rx_valid && !i_rx_ready) begin
        o_rx_overrun <= 1'b1;
      end else if (accept) begin
        o_rx_overrun <= 1'b0;
      end
    end
  end

  // R8 autonomous byte handoff to engine
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_word <= BYTE_RST;
      req_tog <= 1'b0;
      pending <= 1'b0;
    end else if (can_load) begin
      tx_word <= load_byte;
      req_tog <= ~req_tog;
      pending <= 1'b1;
    end else if (ack_evt) begin
      pending <= 1'b0;
    end
  end

  // toggle synchronisers from link domain
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_seen <= 1'b0;
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      rx_seen <= 1'b0;
    end else begin
      ack_s1 <= ack_tog;
      ack_s2 <= ack_s1;
      ack_seen <= ack_s2;
      rx_s1 <= rx_tog;
      rx_s2 <= rx_s1;
      rx_seen <= rx_s2;
    end
  end

  // ---------------- link domain logic ----------------
  wire new_req = req_s2 ^ req_seen;
  wire start = ~active & tbuf_full;
  wire half_end = active & (divcnt == DIV_W'(SCLK_HALF_CYC - 1));
  wire [BYTE_W-1:0] next_rx = {rxsh[BYTE_W-2:0], miso_s2};

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_seen <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      req_s1 <= req_tog;
      req_s2 <= req_s1;
      req_seen <= req_s2;
      miso_s1 <= i_miso;
      miso_s2 <= miso_s1;
    end
  end

  // R11 transmit buffer feeds shift register
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tbuf <= BYTE_RST;
      tbuf_full <= 1'b0;
      ack_tog <= 1'b0;
    end else begin
      if (new_req) begin
        tbuf <= tx_word;
      end
      tbuf_full <= new_req | (tbuf_full & ~start);
      if (start) begin
        ack_tog <= ~ack_tog;
      end
    end
  end

  // R10 shift engine finishes every started byte
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= BYTE_RST;
      rxsh <= BYTE_RST;
      rx_word <= BYTE_RST;
      rx_tog <= 1'b0;
      bitcnt <= '0;
      divcnt <= '0;
      active <= 1'b0;
      o_sclk <= 1'b0;
      o_mosi <= 1'b0;
    end else if (start) begin
      shreg <= tbuf;
      o_mosi <= tbuf[BYTE_W-1];
      active <= 1'b1;
      bitcnt <= '0;
      divcnt <= '0;
      o_sclk <= 1'b0;
    end else if (active) begin
      divcnt <= half_end ? '0 : divcnt + 1'b1;
      if (half_end && !o_sclk) begin
        o_sclk <= 1'b1;
      end else if (half_end) begin
        o_sclk <= 1'b0;
        rxsh <= next_rx;
        if (bitcnt == BIT_LAST) begin
          active <= 1'b0;
          rx_word <= next_rx;
          rx_tog <= ~rx_tog;
        end else begin
          shreg <= {shreg[BYTE_W-2:0], 1'b0};
          o_mosi <= shreg[BYTE_W-2];
          bitcnt <= bitcnt + 1'b1;
        end
      end
    end
  end
endmodule : spi_xfer_seq
`default_nettype wire

// >>> tb/spi_xfer_seq_asserts.sv
// port checker for the spi transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module spi_xfer_seq_chk
  import spi_seq_pkg::*;
#(
  parameter int NUM_DEV = 2,
  parameter int DEV_W = 1,
  parameter int CNT_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [DEV_W-1:0] i_dev,
  input wire logic [CNT_W-1:0] i_send_count,
  input wire logic i_rx_ready,
  input wire logic [BYTE_W-1:0] o_rx_data,
  input wire logic o_rx_valid,
  input wire logic o_rx_overrun,
  input wire logic [NUM_DEV-1:0] o_busy,
  input wire logic o_done,
  input wire logic [NUM_DEV-1:0] o_cs_n,
  input wire logic o_sclk
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire logic idle = ~|o_busy;
  wire logic free = &o_cs_n;
  sequence s_taken;
    idle && i_req && i_send_count != '0 && i_dev < NUM_DEV;
  endsequence
  sequence s_release;
    o_done && free && idle ##1 !o_done;
  endsequence
  property p_one_sel; $onehot0(~o_cs_n); endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_busy_cs; o_busy == ~o_cs_n; endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("busy differs from select");
  property p_start; s_taken |=> o_busy == (1 << $past(i_dev)); endproperty
  a_start: assert property (p_start) else $error("request not started");
  property p_release; o_done |-> !$past(free) ##0 s_release; endproperty
  a_release: assert property (p_release) else $error("bad release");
  property p_cs_held; $changed(o_cs_n) |-> $past(free) || (free && o_done); endproperty
  a_cs_held: assert property (p_cs_held) else $error("select dropped early");
  property p_sclk_framed; free |-> !o_sclk; endproperty
  a_sclk_framed: assert property (p_sclk_framed) else $error("clock outside frame");
  property p_rx_hold;
    o_rx_valid && !i_rx_ready |=> o_rx_valid && (o_rx_overrun || $stable(o_rx_data));
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte lost");
  property p_busy_min; $rose(|o_busy) |=> (|o_busy) [*3]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
endmodule : spi_xfer_seq_chk
bind spi_xfer_seq spi_xfer_seq_chk #(.NUM_DEV(NUM_DEV), .DEV_W(DEV_W), .CNT_W(CNT_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_dev(i_dev),
  .i_send_count(i_send_count), .i_rx_ready(i_rx_ready), .o_rx_data(o_rx_data),
  .o_rx_valid(o_rx_valid), .o_rx_overrun(o_rx_overrun), .o_busy(o_busy),
  .o_done(o_done), .o_cs_n(o_cs_n), .o_sclk(o_sclk));
`default_nettype wire

// >>> tb/eeprom_slave_model.sv
// behavioural spi eeprom slave: logs bytes, answers base plus byte index
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_model #(
  parameter logic [7:0] BASE = 8'hA0
) (
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso
);
  logic [7:0] got [0:31];
  logic [7:0] sh;
  int nb;
  int nbit;
  initial o_miso = 1'b0;
  always @(negedge i_cs_n) begin
    nb = 0;
    nbit = 0;
    o_miso = BASE[7];
  end
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      sh = {sh[6:0], i_mosi};
      nbit = nbit + 1;
      if (nbit == 8) begin
        if (nb < 32) got[nb] = sh;
        nb = nb + 1;
        nbit = 0;
      end
    end
  end
  always @(negedge i_sclk) begin
    logic [7:0] cur;
    cur = BASE + nb[7:0];
    if (!i_cs_n) o_miso = cur[7-nbit];
  end
  // released line shows inverse
  always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule : eeprom_slave_model
`default_nettype wire

// >>> tb/tb_spi_xfer_seq.sv
// self-checking bench for the spi transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_spi_xfer_seq;
  import spi_seq_pkg::*;
  logic i_sys_clk, i_link_clk, i_rst_n, i_req, i_tx_valid, i_rx_ready, i_rx_lockstep;
  logic miso0, miso1, o_tx_ready, o_rx_valid, o_rx_overrun, o_done, o_sclk, o_mosi;
  logic [0:0] i_dev;
  logic [7:0] i_send_count, i_recv_count, i_tx_data, o_rx_data;
  logic [1:0] o_busy, o_cs_n;
  logic [7:0] rxq[$];
  int n_errors = 0;
  int n_compared = 0;
  spi_xfer_seq u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk),
    .i_req(i_req), .i_dev(i_dev), .i_send_count(i_send_count), .i_recv_count(i_recv_count),
    .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .i_rx_lockstep(i_rx_lockstep), .o_rx_overrun(o_rx_overrun), .o_busy(o_busy),
    .o_done(o_done), .o_cs_n(o_cs_n), .o_sclk(o_sclk), .o_mosi(o_mosi),
    .i_miso(o_cs_n[0] ? miso1 : miso0));
  eeprom_slave_model u_mem0 (.i_cs_n(o_cs_n[0]), .i_sclk(o_sclk), .i_mosi(o_mosi), .o_miso(miso0));
  eeprom_slave_model u_mem1 (.i_cs_n(o_cs_n[1]), .i_sclk(o_sclk), .i_mosi(o_mosi), .o_miso(miso1));
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  always @(negedge i_sys_clk) if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) rxq.push_back(o_rx_data);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic push(input int n, input logic [7:0] base, output int k);
    logic r;
    k = 0;
    @(posedge i_sys_clk);
    i_tx_valid <= 1'b1;
    i_tx_data <= base;
    repeat (40) begin
      @(negedge i_sys_clk);
      r = o_tx_ready;
      @(posedge i_sys_clk);
      if (r === 1'b1) k++;
      if (k == n) break;
      i_tx_data <= base + k[7:0];
    end
    i_tx_valid <= 1'b0;
  endtask : push
  task automatic start(input logic d, input logic [7:0] s, input logic [7:0] r);
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_dev <= d;
    i_send_count <= s;
    i_recv_count <= r;
    @(posedge i_sys_clk);
    i_req <= 1'b0;
  endtask : start
  task automatic wait_done;
    int c;
    c = 0;
    do begin
      @(negedge i_sys_clk);
      c++;
    end while (o_done !== 1'b1 && c < 5000);
    chk(o_done, 1'b1);
  endtask : wait_done
  task automatic t_fill;
    int k;
    push(17, 8'h30, k);
    chk(k[15:0], 16'h0010);
    chk(o_tx_ready, 1'b0);
    rxq.delete();
    start(1'b0, 8'h10, 8'h02);
    wait_done();
    for (int i = 0; i < 16; i++) chk(u_mem0.got[i], 8'h30 + i[7:0]);
    chk(u_mem0.got[16], FILLER_BYTE);
    chk(u_mem0.got[17], FILLER_BYTE);
    chk(16'(rxq.size()), 16'h0002);
    chk(rxq[0], 8'hB0);
    chk(rxq[1], 8'hB1);
    chk(o_cs_n, 2'h3);
  endtask : t_fill
  task automatic t_tx_only;
    int k;
    realtime t0;
    push(2, 8'hC1, k);
    rxq.delete();
    start(1'b1, 8'h02, 8'h00);
    repeat (4) @(negedge i_sys_clk);
    chk(o_busy, 2'h2);
    chk(o_cs_n, 2'h1);
    @(posedge o_sclk);
    t0 = $realtime;
    @(negedge o_sclk);
    chk(16'(int'($realtime - t0)), 16'(SCLK_HALF_CYC * 15));
    wait_done();
    chk(u_mem1.got[0], 8'hC1);
    chk(u_mem1.got[1], 8'hC2);
    chk(16'(rxq.size()), 16'h0000);
    chk(o_busy, 2'h0);
  endtask : t_tx_only
  task automatic t_overrun;
    int k;
    push(1, 8'h03, k);
    i_rx_ready <= 1'b0;
    start(1'b0, 8'h01, 8'h03);
    wait_done();
    repeat (4) @(negedge i_sys_clk);
    chk(o_rx_overrun, 1'b1);
    chk(o_rx_data, 8'hA3);
    rxq.delete();
    @(posedge i_sys_clk);
    i_rx_ready <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk(o_rx_overrun, 1'b1);
    chk(o_rx_valid, 1'b0);
    chk(rxq[0], 8'hA3);
  endtask : t_overrun
  task automatic t_lockstep;
    int k;
    push(1, 8'h03, k);
    i_rx_lockstep <= 1'b1;
    i_rx_ready <= 1'b0;
    rxq.delete();
    start(1'b0, 8'h01, 8'h02);
    repeat (300) @(negedge i_sys_clk);
    chk(o_busy, 2'h1);
    chk(o_rx_data, 8'hA1);
    @(posedge i_sys_clk);
    i_rx_ready <= 1'b1;
    wait_done();
    chk(rxq[0], 8'hA1);
    chk(rxq[1], 8'hA2);
    chk(o_rx_overrun, 1'b0);
  endtask : t_lockstep
  task automatic t_refused;
    start(1'b0, 8'h00, 8'h01);
    repeat (5) @(negedge i_sys_clk);
    chk(o_busy, 2'h0);
    chk(o_cs_n, 2'h3);
  endtask : t_refused
  initial begin
    i_rst_n = 1'b0;
    i_req = 1'b0;
    i_dev = 1'b0;
    i_send_count = 8'h00;
    i_recv_count = 8'h00;
    i_tx_data = 8'h00;
    i_tx_valid = 1'b0;
    i_rx_ready = 1'b1;
    i_rx_lockstep = 1'b0;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    t_fill();
    t_tx_only();
    t_overrun();
    t_lockstep();
    t_refused();
    complete_run();
  end
  // about 3000 cycles expected, cut off at ten times that
  initial begin
    #3_000_000;
    n_errors++;
    complete_run();
  end
endmodule : tb_spi_xfer_seq
`default_nettype wire
